// ==== verilog/ppi_sfr_bank.sv ====
// What this block does
// RQ1 - Port reads return live pin levels
// RQ2 - Port writes load only that port's latch
// RQ3 - Port A upper four bits read zero
// RQ4 - Power bit 0 low enables C4/C5 wake
// RQ5 - Power bit 1 makes C6/C7 open-drain
// RQ6 - Power bits 3 and 2 read zero
// RQ7 - Resistor option reads C0/C1 from resistor
// RQ8 - Power bit 5 enables low-voltage detector
// RQ9 - Select low: B0 plain pin, interrupt blocked
// RQ10 - Select high: B0 interrupt, wake masked
// RQ11 - Software makes B0 input when selecting interrupt
// RQ12 - Power bit 7 enables watchdog
// RQ13 - Wake register bit low enables B pin wake
// RQ14 - Page bit 2 selects program page
// RQ15 - Page buffer one or three bits wide
// RQ16 - Pull-down register low enables A/B pull-downs
// RQ17 - Port B pull-up register low enables pull-up
// RQ18 - Port C pull-up register low enables pull-up
// RQ19 - Enable bit 0 unmasks timer interrupt
// RQ20 - Enable bit 2 unmasks external interrupt
// RQ21 - Enable bit 7 is global gate
// RQ22 - Taken interrupt clears global enable
// RQ23 - Return from interrupt sets global enable
// RQ24 - Pending flags stick until software clears
// RQ25 - Pull-ups off while pin is output
// RQ26 - Writes take effect at cycle end
`timescale 1ns/1ps
`default_nettype none

module ppi_sfr_bank
  import ppi_pkg::*;
#(
  parameter bit LARGE_MEMORY = 1'b1
) (
  // Clock and reset.
  input  wire logic          clk,
  input  wire logic          reset_n,
  // Core data-memory access and instruction events.
  input  wire ppi_core_req_s core_req,
  output var  logic [7:0]    rd_data,
  output var  logic          rd_valid,
  input  wire logic          return_from_irq_op,
  input  wire logic          timer_overflow,
  input  wire logic          ext_edge_rising,
  output logic               irq_take,
  output logic               irq_request,
  // Direction controls, one means input.
  input  wire logic [3:0]    dir_a,
  input  wire logic [7:0]    dir_b,
  input  wire logic [7:0]    dir_c,
  // Port A pins.
  input  wire logic [3:0]    port_a_pin_in,
  output logic [3:0]         port_a_pin_out,
  output logic [3:0]         port_a_pin_oe,
  output logic [3:0]         port_a_pull_down_on,
  // Port B pins.
  input  wire logic [7:0]    port_b_pin_in,
  output logic [7:0]         port_b_pin_out,
  output logic [7:0]         port_b_pin_oe,
  output logic [7:0]         port_b_pull_up_on,
  output logic [3:0]         port_b_pull_down_on,
  // Port C pins.
  input  wire logic [7:0]    port_c_pin_in,
  output logic [7:0]         port_c_pin_out,
  output logic [7:0]         port_c_pin_oe,
  output logic [7:0]         port_c_pull_up_on,
  input  wire logic [1:0]    resistor_present,
  // System controls.
  output logic               watchdog_on,
  output logic               low_voltage_detector_on,
  output logic [2:0]         program_page_high,
  output logic               ext_irq_pin,
  output logic               wake_event
);

  localparam logic [2:0] PAGE_MASK = LARGE_MEMORY ? PPI_PAGE_MASK_LARGE : PPI_PAGE_MASK_SMALL;

  ppi_state_s st_reg;
  ppi_state_s st_next;

  logic [7:0] port_b_read;
  logic [7:0] port_c_read;
  logic [7:0] read_mux;
  logic       ext_sel;
  logic       ext_event;
  logic [7:0] wake_fall_b;
  logic [1:0] wake_fall_c;
  logic       timer_live;
  logic       ext_live;

  // Pin-side views of the held state.
  always_comb begin
    ext_sel     = st_reg.power_ctrl[PPI_PC_EXT_SEL];
    port_b_read = port_b_pin_in;                         // see RQ1, see RQ10
    port_c_read = port_c_pin_in;                         // see RQ1
    if (st_reg.power_ctrl[PPI_PC_ROPT]) begin
      port_c_read[1:0] = ~resistor_present;              // see RQ7
    end
    // External interrupt path is gated by the select bit.
    ext_irq_pin = ext_sel & port_b_pin_in[0];            // see RQ9, see RQ10
    ext_event   = ext_sel & (ext_edge_rising ? (port_b_pin_in[0] & ~st_reg.prev_b[0])
                                             : (~port_b_pin_in[0] & st_reg.prev_b[0]));
    // Falling-edge wake sources, active-low enables.
    wake_fall_b    = st_reg.prev_b & ~port_b_pin_in & ~st_reg.wake_b;       // see RQ13
    wake_fall_b[0] = wake_fall_b[0] & ~ext_sel;                             // see RQ10
    wake_fall_c    = st_reg.prev_c_mid & ~port_c_pin_in[5:4]
                   & {2{~st_reg.power_ctrl[PPI_PC_WAKE_C]}};                // see RQ4
  end

  // Read multiplexer over the register map.
  always_comb begin
    read_mux = 8'h00;
    if (core_req.addr == PPI_ADDR_PORT_A) begin
      read_mux = {4'h0, port_a_pin_in};                  // see RQ1, see RQ3
    end else if (core_req.addr == PPI_ADDR_PORT_B) begin
      read_mux = port_b_read;
    end else if (core_req.addr == PPI_ADDR_PORT_C) begin
      read_mux = port_c_read;
    end else if (core_req.addr == PPI_ADDR_POWER_CTRL) begin
      read_mux = st_reg.power_ctrl & PPI_PC_IMPL_MASK;   // see RQ6
    end else if (core_req.addr == PPI_ADDR_WAKE_B) begin
      read_mux = st_reg.wake_b;
    end else if (core_req.addr == PPI_ADDR_PAGE_BUF) begin
      read_mux = {5'h00, st_reg.page};                   // see RQ15
    end else if (core_req.addr == PPI_ADDR_PULL_DOWN) begin
      read_mux = st_reg.pull_down;
    end else if (core_req.addr == PPI_ADDR_PULL_UP_B) begin
      read_mux = st_reg.pull_up_b;
    end else if (core_req.addr == PPI_ADDR_PULL_UP_C) begin
      read_mux = st_reg.pull_up_c;
    end else if (core_req.addr == PPI_ADDR_IRQ_ENABLE) begin
      read_mux[PPI_IRQ_TIMER]  = st_reg.timer_irq_on;    // see RQ19
      read_mux[PPI_IRQ_EXT]    = st_reg.ext_irq_on;
      read_mux[PPI_IRQ_GLOBAL] = st_reg.global_irq_on;
    end else if (core_req.addr == PPI_ADDR_IRQ_FLAGS) begin
      read_mux[PPI_IRQ_TIMER]  = st_reg.timer_pending;
      read_mux[PPI_IRQ_EXT]    = st_reg.ext_pending;
    end
  end

  // Next-state logic: register writes, pending flags and interrupt gating.
  always_comb begin
    st_next            = st_reg;
    st_next.prev_b     = port_b_pin_in;
    st_next.prev_c_mid = port_c_pin_in[5:4];
    st_next.rd_valid   = core_req.rd_en;
    st_next.rd_data    = core_req.rd_en ? read_mux : st_reg.rd_data;
    st_next.wake_pulse = (|wake_fall_b) | (|wake_fall_c);
    // Writes land at the end of the writing cycle.
    if (core_req.wr_en) begin                            // see RQ26
      if (core_req.addr == PPI_ADDR_PORT_A) begin
        st_next.latch_a = core_req.wr_data[3:0];         // see RQ2, see RQ3
      end else if (core_req.addr == PPI_ADDR_PORT_B) begin
        st_next.latch_b = core_req.wr_data;              // see RQ2
      end else if (core_req.addr == PPI_ADDR_PORT_C) begin
        st_next.latch_c = core_req.wr_data;              // see RQ2
      end else if (core_req.addr == PPI_ADDR_POWER_CTRL) begin
        st_next.power_ctrl = core_req.wr_data & PPI_PC_IMPL_MASK; // see RQ6
      end else if (core_req.addr == PPI_ADDR_WAKE_B) begin
        st_next.wake_b = core_req.wr_data;
      end else if (core_req.addr == PPI_ADDR_PAGE_BUF) begin
        st_next.page = core_req.wr_data[2:0] & PAGE_MASK; // see RQ15
      end else if (core_req.addr == PPI_ADDR_PULL_DOWN) begin
        st_next.pull_down = core_req.wr_data;
      end else if (core_req.addr == PPI_ADDR_PULL_UP_B) begin
        st_next.pull_up_b = core_req.wr_data;
      end else if (core_req.addr == PPI_ADDR_PULL_UP_C) begin
        st_next.pull_up_c = core_req.wr_data;
      end else if (core_req.addr == PPI_ADDR_IRQ_ENABLE) begin
        st_next.timer_irq_on  = core_req.wr_data[PPI_IRQ_TIMER];  // see RQ19
        st_next.ext_irq_on    = core_req.wr_data[PPI_IRQ_EXT];    // see RQ20
        st_next.global_irq_on = core_req.wr_data[PPI_IRQ_GLOBAL]; // see RQ21
      end else if (core_req.addr == PPI_ADDR_IRQ_FLAGS) begin
        st_next.timer_pending = core_req.wr_data[PPI_IRQ_TIMER];
        st_next.ext_pending   = core_req.wr_data[PPI_IRQ_EXT];
      end
    end
    // Hardware set wins over a software clear in the same cycle.
    if (timer_overflow) begin
      st_next.timer_pending = 1'b1;                      // see RQ24
    end
    if (ext_event) begin
      st_next.ext_pending = 1'b1;                        // see RQ24
    end
    // Returning from service re-opens the global gate.
    if (return_from_irq_op) begin
      st_next.global_irq_on = 1'b1;                      // see RQ23
    end
    // Taking an interrupt closes the gate; this wins over any write.
    timer_live = st_reg.timer_pending & st_reg.timer_irq_on;
    ext_live   = st_reg.ext_pending & st_reg.ext_irq_on;
    st_next.irq_take = st_reg.global_irq_on & (timer_live | ext_live); // see RQ21
    if (st_next.irq_take) begin
      st_next.global_irq_on = 1'b0;                      // see RQ22
    end
  end

  // State register.
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      st_reg               <= '0;
      st_reg.latch_a       <= PPI_RST_LATCH[3:0];
      st_reg.latch_b       <= PPI_RST_LATCH;
      st_reg.latch_c       <= PPI_RST_LATCH;
      st_reg.power_ctrl    <= PPI_RST_POWER_CTRL;
      st_reg.wake_b        <= PPI_RST_ACT_LOW;
      st_reg.page          <= PPI_RST_PAGE;
      st_reg.pull_down     <= PPI_RST_ACT_LOW;
      st_reg.pull_up_b     <= PPI_RST_ACT_LOW;
      st_reg.pull_up_c     <= PPI_RST_ACT_LOW;
    end else begin
      st_reg <= st_next;
    end
  end

  // Pin drive: latch out where the direction bit selects output.
  always_comb begin
    port_a_pin_out = st_reg.latch_a;                     // see RQ2
    port_a_pin_oe  = ~dir_a;
    port_b_pin_out = st_reg.latch_b;
    port_b_pin_oe  = ~dir_b;
    port_c_pin_out = st_reg.latch_c;
    port_c_pin_oe  = ~dir_c;
    // Open drain on C6/C7 drives only a low.
    if (st_reg.power_ctrl[PPI_PC_OPEN_DR]) begin
      port_c_pin_out[7:6] = 2'h0;                        // see RQ5
      port_c_pin_oe[7:6]  = ~dir_c[7:6] & ~st_reg.latch_c[7:6];
    end
    // Weak pulls apply only to input pins.
    port_a_pull_down_on = ~st_reg.pull_down[3:0] & dir_a;       // see RQ16
    port_b_pull_down_on = ~st_reg.pull_down[7:4] & dir_b[3:0];  // see RQ16
    port_b_pull_up_on   = ~st_reg.pull_up_b & dir_b;            // see RQ17, see RQ25
    port_c_pull_up_on   = ~st_reg.pull_up_c & dir_c;            // see RQ18, see RQ25
  end

  // System control and core-facing outputs.
  always_comb begin
    watchdog_on             = st_reg.power_ctrl[PPI_PC_WDOG];   // see RQ12
    low_voltage_detector_on = st_reg.power_ctrl[PPI_PC_LVD];    // see RQ8
    program_page_high       = st_reg.page;                      // see RQ14
    rd_data                 = st_reg.rd_data;
    rd_valid                = st_reg.rd_valid;
    irq_take                = st_reg.irq_take;
    wake_event              = st_reg.wake_pulse;
    irq_request             = st_reg.global_irq_on & (timer_live | ext_live); // see RQ21
  end

endmodule : ppi_sfr_bank

`default_nettype wire

// ==== verilog/ppi_pkg.sv ====
`default_nettype none

package ppi_pkg;

  // Data-memory addresses of the bank.
  localparam logic [5:0] PPI_ADDR_PORT_A     = 6'h05;
  localparam logic [5:0] PPI_ADDR_PORT_B     = 6'h06;
  localparam logic [5:0] PPI_ADDR_PORT_C     = 6'h07;
  localparam logic [5:0] PPI_ADDR_POWER_CTRL = 6'h08;
  localparam logic [5:0] PPI_ADDR_WAKE_B     = 6'h09;
  localparam logic [5:0] PPI_ADDR_PAGE_BUF   = 6'h0A;
  localparam logic [5:0] PPI_ADDR_PULL_DOWN  = 6'h0B;
  localparam logic [5:0] PPI_ADDR_PULL_UP_B  = 6'h0C;
  localparam logic [5:0] PPI_ADDR_PULL_UP_C  = 6'h0D;
  localparam logic [5:0] PPI_ADDR_IRQ_ENABLE = 6'h0E;
  localparam logic [5:0] PPI_ADDR_IRQ_FLAGS  = 6'h0F;

  // Field positions of the power and pin control register.
  localparam int PPI_PC_WAKE_C   = 0;
  localparam int PPI_PC_OPEN_DR  = 1;
  localparam int PPI_PC_ROPT     = 4;
  localparam int PPI_PC_LVD      = 5;
  localparam int PPI_PC_EXT_SEL  = 6;
  localparam int PPI_PC_WDOG     = 7;
  localparam logic [7:0] PPI_PC_IMPL_MASK = 8'hF3;

  // Field positions of the interrupt enable register; the flag register shares the timer and external ones.
  localparam int PPI_IRQ_TIMER   = 0;
  localparam int PPI_IRQ_EXT     = 2;
  localparam int PPI_IRQ_GLOBAL  = 7;

  // Page buffer: one bit in the small variant, three in the large one.
  localparam int PPI_PAGE_SEL    = 2;
  localparam logic [2:0] PPI_PAGE_MASK_LARGE = 3'h7;
  localparam logic [2:0] PPI_PAGE_MASK_SMALL = 3'h4;

  // Reset values.
  localparam logic [7:0] PPI_RST_LATCH      = 8'h00;
  localparam logic [7:0] PPI_RST_POWER_CTRL = 8'h81;
  localparam logic [7:0] PPI_RST_ACT_LOW    = 8'hFF;
  localparam logic [2:0] PPI_RST_PAGE       = 3'h0;

  // All registered state of the bank.
  typedef struct packed {
    logic [3:0] latch_a;
    logic [7:0] latch_b;
    logic [7:0] latch_c;
    logic [7:0] power_ctrl;
    logic [7:0] wake_b;
    logic [2:0] page;
    logic [7:0] pull_down;
    logic [7:0] pull_up_b;
    logic [7:0] pull_up_c;
    logic       timer_irq_on;
    logic       ext_irq_on;
    logic       global_irq_on;
    logic       timer_pending;
    logic       ext_pending;
    logic [7:0] prev_b;
    logic [1:0] prev_c_mid;
    logic [7:0] rd_data;
    logic       rd_valid;
    logic       wake_pulse;
    logic       irq_take;
  } ppi_state_s;

  // Core data-memory access.
  typedef struct packed {
    logic [5:0] addr;
    logic       wr_en;
    logic       rd_en;
    logic [7:0] wr_data;
  } ppi_core_req_s;

endpackage : ppi_pkg

`default_nettype wire

// ==== bench/ppi_sfr_bank_checker.sv ====
`timescale 1ns/1ps
`default_nettype none

// Watches the bank ports for read, write and interrupt timing.
module ppi_sfr_bank_checker
  import ppi_pkg::*;
#(
  parameter bit LARGE_MEMORY = 1'b1
) (
  // Clock and reset.
  input wire logic          clk,
  input wire logic          reset_n,
  // Core side.
  input wire ppi_core_req_s core_req,
  input wire logic [7:0]    rd_data,
  input wire logic          rd_valid,
  input wire logic          irq_take,
  input wire logic          irq_request,
  // Pins and controls.
  input wire logic [7:0]    dir_b,
  input wire logic [7:0]    dir_c,
  input wire logic [3:0]    port_a_pin_in,
  input wire logic [7:0]    port_b_pin_in,
  input wire logic [7:0]    port_b_pull_up_on,
  input wire logic [7:0]    port_c_pull_up_on,
  input wire logic          watchdog_on,
  input wire logic          low_voltage_detector_on,
  input wire logic [2:0]    program_page_high,
  input wire logic          ext_irq_pin
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Accesses to one address.
  sequence rd_at(logic [5:0] a);
    core_req.rd_en && core_req.addr == a;
  endsequence
  sequence wr_at(logic [5:0] a);
    core_req.wr_en && core_req.addr == a;
  endsequence

  read_pulse_a: assert property (rd_valid == $past(core_req.rd_en))
    else $error("read answer timing wrong");
  port_b_read_a: assert property (rd_at(PPI_ADDR_PORT_B) |=>
    rd_data == $past(port_b_pin_in))
    else $error("port b read not pin level");
  port_a_read_a: assert property (rd_at(PPI_ADDR_PORT_A) |=>
    rd_data == {4'h0, $past(port_a_pin_in)})
    else $error("port a read wrong");
  power_read_a: assert property (rd_at(PPI_ADDR_POWER_CTRL) |=> rd_data[3:2] == 2'b00)
    else $error("power unused bits not zero");
  ctrl_write_a: assert property (wr_at(PPI_ADDR_POWER_CTRL) |=>
    watchdog_on == $past(core_req.wr_data[PPI_PC_WDOG])
    && low_voltage_detector_on == $past(core_req.wr_data[PPI_PC_LVD]))
    else $error("power control outputs wrong");
  page_write_a: assert property (wr_at(PPI_ADDR_PAGE_BUF) |=>
    program_page_high == ($past(core_req.wr_data[2:0]) & (LARGE_MEMORY ? 3'h7 : 3'h4)))
    else $error("page buffer wrong");
  pull_up_out_a: assert property (
    ((port_b_pull_up_on & ~dir_b) | (port_c_pull_up_on & ~dir_c)) == 8'h00)
    else $error("pull-up on at output pin");
  ext_gate_a: assert property (wr_at(PPI_ADDR_POWER_CTRL) ##0 !core_req.wr_data[6] |=>
    !ext_irq_pin)
    else $error("interrupt pin path not blocked");
  irq_take_a: assert property (irq_request |=> irq_take)
    else $error("request not taken");
  take_clears_a: assert property (irq_take |-> !irq_request)
    else $error("global enable not cleared");
endmodule : ppi_sfr_bank_checker

`default_nettype wire

// ==== bench/ppi_core_model.sv ====
`timescale 1ns/1ps
`default_nettype none

// Core model: one data-memory access per instruction, launched at the falling edge.
module ppi_core_model
  import ppi_pkg::*;
(
  // Clock and read answer.
  input  wire logic       clk,
  input  wire logic [7:0] rd_data,
  input  wire logic       rd_valid,
  // Request to the bank.
  output var ppi_core_req_s core_req
);
  initial core_req = '0;

  // Write strobe lasts one cycle; the data bus then carries junk.
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    @(negedge clk) core_req = '{a, 1'b1, 1'b0, d};
    @(negedge clk) core_req = '{a, 1'b0, 1'b0, ~d};
  endtask : wr

  // Read answer is taken in the cycle after the strobe, unknown if not valid.
  task automatic rd(input logic [5:0] a, output logic [7:0] d);
    @(negedge clk) core_req = '{a, 1'b0, 1'b1, 8'h00};
    @(negedge clk) core_req.rd_en = 1'b0;
    d = (rd_valid === 1'b1) ? rd_data : 8'hXX;
  endtask : rd
endmodule : ppi_core_model

`default_nettype wire

// ==== bench/ppi_sfr_bank_tb.sv ====
`timescale 1ns/1ps
`default_nettype none

// Self-checking bench for the register bank.
module ppi_sfr_bank_tb;
  import ppi_pkg::*;
  logic          clk = 1'b0, reset_n = 1'b0, return_from_irq_op = 1'b0;
  logic          timer_overflow = 1'b0, ext_edge_rising = 1'b1;
  logic [3:0]    dir_a = 4'h0, port_a_pin_in = 4'h5;
  logic [7:0]    dir_b = 8'hFF, dir_c = 8'hFF, port_b_pin_in = 8'hFF, port_c_pin_in = 8'hFF;
  logic [1:0]    resistor_present = 2'b01;
  ppi_core_req_s core_req;
  logic [7:0]    rd_data, port_b_pin_out, port_b_pin_oe, port_b_pull_up_on;
  logic [7:0]    port_c_pin_out, port_c_pin_oe, port_c_pull_up_on;
  logic [3:0]    port_a_pin_out, port_a_pin_oe, port_a_pull_down_on, port_b_pull_down_on;
  logic [2:0]    program_page_high;
  logic          rd_valid, irq_take, irq_request, watchdog_on, low_voltage_detector_on;
  logic          ext_irq_pin, wake_event;
  int            failures = 0, samples_checked = 0, wakes = 0, takes = 0;
  logic [7:0]    rst_tab [9] = '{8'h81, 8'hFF, 8'h00, 8'hFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 8'h00};

  always #2.5 clk = ~clk;

  ppi_core_model core (.clk, .rd_data, .rd_valid, .core_req);
  ppi_sfr_bank ppi_sfr_bank_inst (.*);

  // Counts the one-cycle wake and take pulses.
  always @(posedge clk) begin
    wakes += int'(wake_event === 1'b1);
    takes += int'(irq_take === 1'b1);
  end

  // Compares one value and reports a mismatch.
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk

  // Reads one register and compares it.
  task automatic chk_reg(input logic [5:0] a, input logic [7:0] e);
    logic [7:0] d;
    core.rd(a, d);
    chk(d, e);
  endtask : chk_reg

  // Prints the verdict and ends the run.
  task automatic print_verdict;
    if (failures == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  // Cuts a hang short.
  initial begin
    #20000;
    failures++;
    print_verdict();
  end

  // Main sequence.
  initial begin
    repeat (5) @(negedge clk);
    reset_n = 1'b1;
    for (int i = 0; i < 9; i++) chk_reg(6'h08 + 6'(i), rst_tab[i]);
    chk_reg(PPI_ADDR_PORT_A, 8'h05);
    chk_reg(PPI_ADDR_PORT_C, 8'hFF);
    core.wr(PPI_ADDR_PORT_A, 8'hFA);
    chk({port_a_pin_oe, port_a_pin_out}, 8'hFA);
    chk(port_b_pin_out, 8'h00);
    core.wr(PPI_ADDR_POWER_CTRL, 8'hFF);
    chk_reg(PPI_ADDR_POWER_CTRL, 8'hF3);
    chk({6'h00, watchdog_on, low_voltage_detector_on}, 8'h03);
    dir_c = 8'h00;
    core.wr(PPI_ADDR_POWER_CTRL, 8'h12);
    chk({6'h00, watchdog_on, low_voltage_detector_on}, 8'h00);
    chk_reg(PPI_ADDR_PORT_C, 8'hFE);
    core.wr(PPI_ADDR_PORT_C, 8'hC3);
    chk(port_c_pin_oe, 8'h3F);
    chk(port_c_pin_out & 8'hC0, 8'h00);
    core.wr(PPI_ADDR_POWER_CTRL, 8'h10);
    chk(port_c_pin_oe, 8'hFF);
    dir_b = 8'h33;
    dir_c = 8'h0F;
    dir_a = 4'hF;
    core.wr(PPI_ADDR_PULL_UP_B, 8'h0F);
    chk(port_b_pull_up_on, 8'h30);
    chk(port_b_pin_oe, 8'hCC);
    core.wr(PPI_ADDR_PULL_UP_C, 8'h00);
    chk(port_c_pull_up_on, 8'h0F);
    core.wr(PPI_ADDR_PULL_DOWN, 8'h5A);
    chk({port_b_pull_down_on, port_a_pull_down_on}, 8'h25);
    core.wr(PPI_ADDR_PAGE_BUF, 8'hFF);
    chk_reg(PPI_ADDR_PAGE_BUF, 8'h07);
    chk({5'h00, program_page_high}, 8'h07);
    core.wr(PPI_ADDR_WAKE_B, 8'hFE);
    port_b_pin_in = 8'hFE;
    repeat (3) @(negedge clk);
    chk(8'(wakes), 8'h01);
    port_c_pin_in = 8'hEF;
    port_b_pin_in = 8'hFF;
    repeat (3) @(negedge clk);
    chk(8'(wakes), 8'h02);
    core.wr(PPI_ADDR_POWER_CTRL, 8'h51);
    port_b_pin_in = 8'hFE;
    repeat (3) @(negedge clk);
    chk(8'(wakes), 8'h02);
    chk({7'h00, ext_irq_pin}, 8'h00);
    chk_reg(PPI_ADDR_PORT_B, 8'hFE);
    core.wr(PPI_ADDR_IRQ_ENABLE, 8'hFF);
    chk_reg(PPI_ADDR_IRQ_ENABLE, 8'h85);
    core.wr(PPI_ADDR_IRQ_ENABLE, 8'h81);
    port_b_pin_in = 8'hFF;
    repeat (3) @(negedge clk);
    chk(8'(takes), 8'h00);
    chk({7'h00, ext_irq_pin}, 8'h01);
    chk_reg(PPI_ADDR_IRQ_FLAGS, 8'h04);
    core.wr(PPI_ADDR_IRQ_FLAGS, 8'h00);
    timer_overflow = 1'b1;
    @(negedge clk) timer_overflow = 1'b0;
    repeat (3) @(negedge clk);
    chk(8'(takes), 8'h01);
    chk_reg(PPI_ADDR_IRQ_ENABLE, 8'h01);
    chk_reg(PPI_ADDR_IRQ_FLAGS, 8'h01);
    chk(8'(takes), 8'h01);
    core.wr(PPI_ADDR_IRQ_FLAGS, 8'h00);
    return_from_irq_op = 1'b1;
    @(negedge clk) return_from_irq_op = 1'b0;
    chk_reg(PPI_ADDR_IRQ_ENABLE, 8'h81);
    print_verdict();
  end
endmodule : ppi_sfr_bank_tb

bind ppi_sfr_bank ppi_sfr_bank_checker #(.LARGE_MEMORY(LARGE_MEMORY)) ppi_sfr_bank_checker_inst (.*);

`default_nettype wire
